// ==== inc/qer_params.svh ====
/*
  Constants for the quadrature encoder rescaler: register offsets,
  control field positions, reset values and widths.
  Assumes it is included by bare name by the design files and the bench.
*/
`ifndef QER_PARAMS_SVH
`define QER_PARAMS_SVH

`define QER_ADDR_W 8
`define QER_DATA_W 32
`define QER_LINES 6
`define QER_LSEL_W 3
`define QER_FACTOR_W 16
`define QER_PEND_W 20
`define QER_BACKLOG_W 16
`define QER_CTRL_W 7

`define QER_OFF_CTRL 8'h00
`define QER_OFF_MULT 8'h04
`define QER_OFF_DIV 8'h08
`define QER_OFF_LSEL 8'h0c
`define QER_OFF_LDIR 8'h10
`define QER_OFF_POS 8'h14
`define QER_OFF_TRIG 8'h18

`define QER_CTRL_COND 0
`define QER_CTRL_ORDER 1
`define QER_CTRL_DIR 2
`define QER_CTRL_AROUTE 3
`define QER_CTRL_BROUTE_LO 4
`define QER_CTRL_BROUTE_HI 5
`define QER_CTRL_EDGE 6

`define QER_CTRL_RST 7'h10
`define QER_MULT_RST 16'h0001
`define QER_DIV_RST 16'h0001
`define QER_LSEL_RST 3'h0
`define QER_LSEL_LAST 3'h5

`define QER_LINE1 0
`define QER_LINE2 1
`define QER_LINE3 2
`define QER_LINE4 3

`endif

// ==== inc/qer_pkg.sv ====
/*
  Types for the quadrature encoder rescaler: the encodings of its
  control fields. Assumes qer_params.svh is on the include path.
*/
package qer_pkg;

    typedef enum logic {cond_position = 1'b0, cond_motion = 1'b1} encoder_pulse_condition_e;

    typedef enum logic {
        multiply_then_divide = 1'b0,
        divide_then_multiply = 1'b1
    } scaling_sequence_select_e;

    typedef enum logic {phase_second_leads = 1'b0, phase_first_leads = 1'b1} forward_phase_order_e;

    typedef enum logic {low_to_high_only = 1'b0, both_transitions = 1'b1} count_edge_select_e;

    typedef enum logic [1:0] {
        route_gnd = 2'h0,
        route_line2 = 2'h1,
        route_line4 = 2'h2
    } phase_second_line_route_e;

endpackage

// ==== hw/pulse_rescaler.sv ====
/*
  Pulse rate rescaler: a multiplier stage and a divider stage, chained in
  either order. Assumes one-cycle input pulses and factors held steady by
  software; a factor of zero acts as one.
*/
`timescale 1ns/100ps
`default_nettype none
`include "qer_params.svh"
module pulse_rescaler
    import qer_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input wire logic [`QER_FACTOR_W-1:0] multiply_factor,
    input wire logic [`QER_FACTOR_W-1:0] divide_factor,
    input wire scaling_sequence_select_e sequence_sel,
    // pulses
    input wire logic pulse_in,
    output logic pulse_out
);
    logic [`QER_PEND_W-1:0] pend_q, pend_d;
    logic [`QER_FACTOR_W-1:0] div_cnt_q, div_cnt_d;
    logic pulse_out_q;
    logic [`QER_FACTOR_W-1:0] mult_eff, div_last;
    logic mul_in, mul_out, div_in, div_out, pend_nz, div_first;
    logic [`QER_PEND_W:0] pend_sum;

    assign mult_eff = (multiply_factor == '0) ? `QER_FACTOR_W'(1) : multiply_factor;
    assign div_last = (divide_factor == '0) ? '0 : divide_factor - `QER_FACTOR_W'(1);
    assign div_first = (sequence_sel == divide_then_multiply);

    // stage order
    assign mul_in = div_first ? div_out : pulse_in;
    assign div_in = div_first ? pulse_in : mul_out;

    // multiplier: each input pulse queues mult_eff output pulses, one per clock
    assign pend_nz = (pend_q != '0);
    assign mul_out = pend_nz;
    assign pend_sum = {1'b0, pend_q} - {{`QER_PEND_W{1'b0}}, pend_nz}
        + {{(`QER_PEND_W + 1 - `QER_FACTOR_W){1'b0}}, mul_in ? mult_eff : `QER_FACTOR_W'(0)};
    // saturate rather than wrap: a wrap would silently drop a burst
    assign pend_d = pend_sum[`QER_PEND_W] ? '1 : pend_sum[`QER_PEND_W-1:0];

    // divider: one output pulse per divide_factor input pulses
    assign div_out = div_in && (div_cnt_q >= div_last);
    assign div_cnt_d = !div_in ? div_cnt_q : (div_out ? '0 : div_cnt_q + `QER_FACTOR_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
            div_cnt_q <= '0;
            pulse_out_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            div_cnt_q <= div_cnt_d;
            pulse_out_q <= div_first ? mul_out : div_out;
        end
    end

    assign pulse_out = pulse_out_q;

    a_div_every_nth: assert property (
        @(posedge pclk) disable iff (!presetn)
        (div_in && div_cnt_q < div_last) |-> !div_out)
        else $error("divider fired before its count was reached");

    a_mul_burst_len: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mul_in && !pend_nz && mult_eff == `QER_FACTOR_W'(2)) |=> mul_out ##1 mul_out)
        else $error("multiplier burst shorter than its factor");

endmodule
`default_nettype wire

// ==== hw/quadrature_encoder_rescaler.sv ====
/*
  Quadrature encoder front end: line routing, two-stage synchronisers,
  edge qualification, direction decode, position and motion trigger
  generation, and rate rescaling, configured over an APB slave.
  Assumes an APB master on pclk and encoder lines that may be asynchronous.
*/
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "qer_params.svh"
// Behaviour
// - pulse condition setting selects position or motion
// - position mode pulses each new forward increment
// - after reversal, silent until reversal point passed
// - motion mode pulses every increment, either direction
// - multiply-first order multiplies before dividing
// - divide-first order divides before multiplying
// - programmable multiply factor raises pulse rate
// - programmable divide factor lowers pulse rate
// - clockwise setting: second phase leading is forward
// - other setting: first phase leading is forward
// - first phase routed from line one or three
// - second phase from line two, four, or ground
// - rising setting counts low-to-high transitions only
// - both-edge setting counts every transition
// - line index selects one of six lines
module quadrature_encoder_rescaler
    import qer_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`QER_ADDR_W-1:0] paddr,
    input wire logic [`QER_DATA_W-1:0] pwdata,
    output logic [`QER_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // physical io lines
    input wire logic [`QER_LINES-1:0] line_in,
    input wire logic [`QER_LINES-1:0] line_is_output,
    // trigger to the line trigger logic
    output logic encoder_trigger
);
    // registers
    logic [`QER_CTRL_W-1:0] ctrl_q;
    logic [`QER_FACTOR_W-1:0] mult_q;
    logic [`QER_FACTOR_W-1:0] div_q;
    logic [`QER_LSEL_W-1:0] lsel_q;
    logic [`QER_DATA_W-1:0] prdata_q;
    logic [`QER_DATA_W-1:0] pos_q, pos_d;
    logic [`QER_DATA_W-1:0] trig_cnt_q;
    logic [`QER_LINES-1:0] sync1_q;
    logic [`QER_LINES-1:0] sync2_q;
    logic a_q, b_q;
    logic [`QER_BACKLOG_W-1:0] backlog_q, backlog_d;
    logic raw_pulse_q, raw_pulse_d;

    // bus decode
    logic wr_en, rd_setup, addr_hit;
    logic hit_ctrl, hit_mult, hit_div, hit_lsel, hit_ldir, hit_pos, hit_trig;
    logic [`QER_DATA_W-1:0] rd_mux;
    logic lsel_ok, sel_dir;

    // configuration fields
    encoder_pulse_condition_e cond;
    scaling_sequence_select_e order;
    forward_phase_order_e fwd_order;
    count_edge_select_e edge_sel;
    phase_second_line_route_e b_route;
    logic a_route_line3;

    // decode
    logic [`QER_LINES-1:0] line_usable;
    logic ph_a, ph_b, b_used;
    logic a_rise, b_rise, a_chg, b_chg, a_ev, b_ev, both_chg;
    logic step_valid, a_leads, fwd, backlog_nz, backlog_full;
    logic rescaled;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    assign hit_ctrl = (paddr == `QER_OFF_CTRL);
    assign hit_mult = (paddr == `QER_OFF_MULT);
    assign hit_div = (paddr == `QER_OFF_DIV);
    assign hit_lsel = (paddr == `QER_OFF_LSEL);
    assign hit_ldir = (paddr == `QER_OFF_LDIR);
    assign hit_pos = (paddr == `QER_OFF_POS);
    assign hit_trig = (paddr == `QER_OFF_TRIG);
    assign addr_hit = hit_ctrl | hit_mult | hit_div | hit_lsel | hit_ldir | hit_pos | hit_trig;
    // unmapped addresses answer with an error and read as zero
    assign pslverr = psel && penable && !addr_hit;

    // out-of-range line indices are ignored so the selector stays on a real line
    assign lsel_ok = (pwdata[`QER_LSEL_W-1:0] <= `QER_LSEL_LAST);
    assign sel_dir = line_is_output[lsel_q];

    always_comb begin
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux[`QER_CTRL_W-1:0] = ctrl_q;
        end else if (hit_mult) begin
            rd_mux[`QER_FACTOR_W-1:0] = mult_q;
        end else if (hit_div) begin
            rd_mux[`QER_FACTOR_W-1:0] = div_q;
        end else if (hit_lsel) begin
            rd_mux[`QER_LSEL_W-1:0] = lsel_q;
        end else if (hit_ldir) begin
            rd_mux[0] = sel_dir;
        end else if (hit_pos) begin
            rd_mux = pos_q;
        end else if (hit_trig) begin
            rd_mux = trig_cnt_q;
        end
    end

    // read data is captured in the setup cycle so it stands through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `QER_CTRL_RST;
            mult_q <= `QER_MULT_RST;
            div_q <= `QER_DIV_RST;
            lsel_q <= `QER_LSEL_RST;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata[`QER_CTRL_W-1:0];
            end
            if (hit_mult) begin
                mult_q <= pwdata[`QER_FACTOR_W-1:0];
            end
            if (hit_div) begin
                div_q <= pwdata[`QER_FACTOR_W-1:0];
            end
            if (hit_lsel && lsel_ok) begin
                lsel_q <= pwdata[`QER_LSEL_W-1:0];
            end
        end
    end

    assign cond = encoder_pulse_condition_e'(ctrl_q[`QER_CTRL_COND]);
    assign order = scaling_sequence_select_e'(ctrl_q[`QER_CTRL_ORDER]);
    assign fwd_order = forward_phase_order_e'(ctrl_q[`QER_CTRL_DIR]);
    assign a_route_line3 = ctrl_q[`QER_CTRL_AROUTE];
    assign b_route = phase_second_line_route_e'(ctrl_q[`QER_CTRL_BROUTE_HI:`QER_CTRL_BROUTE_LO]);
    assign edge_sel = count_edge_select_e'(ctrl_q[`QER_CTRL_EDGE]);

    // two-flop synchroniser on every line; stage one feeds stage two only
    for (genvar i = 0; i < `QER_LINES; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
            end else begin
                sync1_q[i] <= line_in[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
        // a line driven as an output reads low to the encoder
        assign line_usable[i] = sync2_q[i] && !line_is_output[i];
    end

    // phase routing; reserved route code behaves as ground
    assign ph_a = a_route_line3 ? line_usable[`QER_LINE3] : line_usable[`QER_LINE1];
    assign b_used = (b_route == route_line2) || (b_route == route_line4);
    assign ph_b = (b_route == route_line2) ? line_usable[`QER_LINE2] :
        (b_route == route_line4) ? line_usable[`QER_LINE4] : 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= ph_a;
            b_q <= ph_b;
        end
    end

    assign a_chg = ph_a ^ a_q;
    assign b_chg = (ph_b ^ b_q) && b_used;
    assign a_rise = ph_a && !a_q;
    assign b_rise = ph_b && !b_q && b_used;
    assign a_ev = (edge_sel == both_transitions) ? a_chg : a_rise;
    assign b_ev = (edge_sel == both_transitions) ? b_chg : b_rise;
    // both phases moving together is an illegal jump and counts nothing
    assign both_chg = a_chg && b_chg;
    assign step_valid = (a_ev || b_ev) && !both_chg;

    // phase order: first phase leads when it moves to differ, or second moves to agree
    assign a_leads = a_ev ? (ph_a != ph_b) : (ph_b == ph_a);
    assign fwd = !b_used ||
        ((fwd_order == phase_first_leads) ? a_leads : !a_leads);

    // backlog counts steps still owed after a reversal
    assign backlog_nz = (backlog_q != '0);
    assign backlog_full = (backlog_q == '1);
    assign raw_pulse_d = step_valid &&
        ((cond == cond_motion) || (fwd && !backlog_nz));

    always_comb begin
        backlog_d = backlog_q;
        if (cond == cond_motion) begin
            backlog_d = '0;
        end else if (step_valid && !fwd && !backlog_full) begin
            backlog_d = backlog_q + `QER_BACKLOG_W'(1);
        end else if (step_valid && fwd && backlog_nz) begin
            backlog_d = backlog_q - `QER_BACKLOG_W'(1);
        end
    end

    assign pos_d = !step_valid ? pos_q :
        (fwd ? pos_q + `QER_DATA_W'(1) : pos_q - `QER_DATA_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backlog_q <= '0;
            raw_pulse_q <= 1'b0;
            pos_q <= '0;
            trig_cnt_q <= '0;
        end else begin
            backlog_q <= backlog_d;
            raw_pulse_q <= raw_pulse_d;
            pos_q <= pos_d;
            trig_cnt_q <= trig_cnt_q + {{(`QER_DATA_W - 1){1'b0}}, rescaled};
        end
    end

    pulse_rescaler u_rescaler (
        .pclk(pclk),
        .presetn(presetn),
        .multiply_factor(mult_q),
        .divide_factor(div_q),
        .sequence_sel(order),
        .pulse_in(raw_pulse_q),
        .pulse_out(rescaled)
    );
    assign encoder_trigger = rescaled;

    a_pos_fwd_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (step_valid && fwd && !backlog_nz && cond == cond_position) |=> raw_pulse_q)
        else $error("forward step in position mode gave no pulse");

    a_pos_rev_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cond == cond_position && (backlog_nz || (step_valid && !fwd))) |=> !raw_pulse_q)
        else $error("pulse emitted before reversal point was passed");

    a_backlog_grow: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cond == cond_position && step_valid && !fwd && !backlog_full)
        |=> backlog_q == $past(backlog_q) + `QER_BACKLOG_W'(1))
        else $error("reverse step not recorded in backlog");

    a_motion_every: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cond == cond_motion && step_valid) |=> raw_pulse_q)
        else $error("motion step gave no pulse");

    a_cw_forward: assert property (
        @(posedge pclk) disable iff (!presetn)
        (b_used && fwd_order == phase_second_leads && b_ev && !a_chg && ph_b != ph_a)
        |-> fwd)
        else $error("second phase lead not taken as forward");

    a_ccw_forward: assert property (
        @(posedge pclk) disable iff (!presetn)
        (b_used && fwd_order == phase_first_leads && a_ev && !b_chg && ph_a != ph_b)
        |-> fwd)
        else $error("first phase lead not taken as forward");

    a_rise_only: assert property (
        @(posedge pclk) disable iff (!presetn)
        (edge_sel == low_to_high_only && step_valid) |-> (a_rise || b_rise))
        else $error("step counted on a falling edge in rising mode");

    a_fall_counts: assert property (
        @(posedge pclk) disable iff (!presetn)
        (edge_sel == both_transitions && !b_used && !ph_a && a_q) |-> step_valid)
        else $error("falling edge not counted in both-edge mode");

    a_single_phase: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!b_used && step_valid) |-> fwd)
        else $error("single phase step not forward");

    a_sync_latency: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($rose(line_in[`QER_LINE1]) && !a_route_line3 && !line_is_output[`QER_LINE1]
            && !b_used && edge_sel == low_to_high_only && !ph_a)
        ##1 ($stable(ctrl_q) && $stable(line_is_output))
        ##1 ($stable(ctrl_q) && $stable(line_is_output)) |-> step_valid)
        else $error("synchronised edge not counted two cycles later");

endmodule
`default_nettype wire

// ==== dv/encoder_model.sv ====
/*
  Behavioural quadrature shaft encoder: one quarter step per request.
  Assumes single-cycle requests on pclk, spaced apart by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module encoder_model (
    // clock
    input wire logic pclk,
    // step request
    input wire logic step_req,
    input wire logic step_fwd,
    // phase outputs
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] quarter_q = 2'h0;
    logic [1:0] quarter_d;
    // forward counts up so the first phase leads; gray order moves one phase per step
    assign quarter_d = step_fwd ? quarter_q + 2'h1 : quarter_q - 2'h1;
    // a real encoder ignores the camera reset, so the shaft position survives it
    always @(posedge pclk) begin
        if (step_req) begin
            quarter_q <= quarter_d;
        end
    end
    assign phase_a = quarter_q[1] ^ quarter_q[0];
    assign phase_b = quarter_q[1];
endmodule
`default_nettype wire

// ==== dv/quadrature_encoder_rescaler_tb_top.sv ====
/*
  Self-checking bench: apb master tasks, one task per scenario, trigger counting.
  Assumes the package, the design files and encoder_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "qer_params.svh"
module quadrature_encoder_rescaler_tb_top
    import qer_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic encoder_trigger;
    logic [5:0] line_in;
    logic [5:0] lio = 6'h00;
    logic a_on3 = 1'b0;
    logic b_on4 = 1'b0;
    logic step_req = 1'b0;
    logic step_fwd = 1'b0;
    logic phase_a;
    logic phase_b;
    logic [31:0] trig_seen = 32'h0;
    logic [31:0] trig_base = 32'h0;
    int mismatches = 0;
    int checks_done = 0;

    always #12.5 pclk = ~pclk;
    // lines 5 and 6 carry the phases too, as noise the routing must ignore
    assign line_in = {phase_a, phase_b, b_on4 ? phase_b : 1'b0, a_on3 ? phase_a : 1'b0,
                      b_on4 ? 1'b0 : phase_b, a_on3 ? 1'b0 : phase_a};

    quadrature_encoder_rescaler dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_is_output(lio),
        .encoder_trigger(encoder_trigger));
    encoder_model shaft (.pclk(pclk), .step_req(step_req), .step_fwd(step_fwd),
        .phase_a(phase_a), .phase_b(phase_b));

    always @(posedge pclk) begin
        if (encoder_trigger === 1'b1) begin
            trig_seen <= trig_seen + 32'h1;
        end
    end

    task summarize;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) mismatches++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    // steps spaced 8 cycles so phases stay stable well beyond the sync delay
    task run(input logic fwd, input int n, input logic [31:0] exp);
        repeat (n) begin
            step_req <= 1'b1;
            step_fwd <= fwd;
            @(posedge pclk);
            step_req <= 1'b0;
            repeat (7) @(posedge pclk);
        end
        repeat (24) @(posedge pclk);
        chk(trig_seen - trig_base, exp);
        trig_base = trig_seen;
    endtask

    function automatic logic [31:0] ctrl(input logic c, input logic o, input logic d,
                                         input logic a, input logic [1:0] b, input logic e);
        ctrl = 32'h0;
        ctrl[`QER_CTRL_COND] = c;
        ctrl[`QER_CTRL_ORDER] = o;
        ctrl[`QER_CTRL_DIR] = d;
        ctrl[`QER_CTRL_AROUTE] = a;
        ctrl[`QER_CTRL_BROUTE_HI:`QER_CTRL_BROUTE_LO] = b;
        ctrl[`QER_CTRL_EDGE] = e;
    endfunction

    task t_regs;
        logic [31:0] r;
        logic e;
        rd(`QER_OFF_CTRL, 32'(`QER_CTRL_RST));
        rd(`QER_OFF_MULT, 32'(`QER_MULT_RST));
        rd(`QER_OFF_DIV, 32'(`QER_DIV_RST));
        rd(`QER_OFF_LSEL, 32'(`QER_LSEL_RST));
        wr(`QER_OFF_TRIG, 32'hffff_ffff);
        rd(`QER_OFF_TRIG, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("t_regs finished");
    endtask

    task t_lines;
        for (int k = 0; k < `QER_LINES; k++) begin
            wr(`QER_OFF_LSEL, 32'(k));
            lio <= 6'h01 << k;
            rd(`QER_OFF_LDIR, 32'h1);
            lio <= ~(6'h01 << k);
            rd(`QER_OFF_LDIR, 32'h0);
        end
        wr(`QER_OFF_LSEL, 32'h6);
        rd(`QER_OFF_LSEL, 32'(`QER_LSEL_LAST));
        lio <= 6'h00; // encoder lines back to inputs before stepping
        $display("t_lines finished");
    endtask

    task t_direction;
        wr(`QER_OFF_CTRL, ctrl(cond_position, multiply_then_divide, phase_first_leads, 1'b0,
                               route_line2, both_transitions));
        run(1'b1, 4, 32'h4);
        run(1'b0, 2, 32'h0);
        run(1'b1, 2, 32'h0);
        run(1'b1, 2, 32'h2);
        rd(`QER_OFF_POS, 32'h6);
        wr(`QER_OFF_CTRL, ctrl(cond_position, multiply_then_divide, phase_second_leads, 1'b0,
                               route_line2, both_transitions));
        run(1'b0, 4, 32'h4);
        run(1'b1, 4, 32'h0);
        $display("t_direction finished");
    endtask

    task t_edges;
        wr(`QER_OFF_CTRL, ctrl(cond_motion, multiply_then_divide, phase_first_leads, 1'b0,
                               route_line2, both_transitions));
        run(1'b1, 3, 32'h3);
        run(1'b0, 3, 32'h3);
        wr(`QER_OFF_CTRL, ctrl(cond_motion, multiply_then_divide, phase_first_leads, 1'b0,
                               route_line2, low_to_high_only));
        run(1'b1, 4, 32'h2);
        run(1'b0, 2, 32'h0);
        $display("t_edges finished");
    endtask

    // both phases sit low here, so swapping the routes makes no edge
    task t_route;
        a_on3 <= 1'b1;
        b_on4 <= 1'b1;
        wr(`QER_OFF_CTRL, ctrl(cond_motion, multiply_then_divide, phase_first_leads, 1'b1,
                               route_line4, both_transitions));
        run(1'b1, 4, 32'h4);
        wr(`QER_OFF_CTRL, ctrl(cond_position, multiply_then_divide, phase_first_leads, 1'b1,
                               route_gnd, both_transitions));
        run(1'b0, 4, 32'h2);
        a_on3 <= 1'b0;
        wr(`QER_OFF_CTRL, ctrl(cond_position, multiply_then_divide, phase_first_leads, 1'b0,
                               route_gnd, low_to_high_only));
        run(1'b1, 4, 32'h1);
        b_on4 <= 1'b0;
        $display("t_route finished");
    endtask

    task t_scale;
        wr(`QER_OFF_CTRL, ctrl(cond_motion, multiply_then_divide, phase_first_leads, 1'b0,
                               route_line2, both_transitions));
        wr(`QER_OFF_MULT, 32'h3);
        run(1'b1, 2, 32'h6);
        wr(`QER_OFF_MULT, 32'h1);
        wr(`QER_OFF_DIV, 32'h2);
        run(1'b1, 4, 32'h2);
        wr(`QER_OFF_MULT, 32'h3);
        wr(`QER_OFF_CTRL, ctrl(cond_motion, divide_then_multiply, phase_first_leads, 1'b0,
                               route_line2, both_transitions));
        run(1'b1, 3, 32'h3);
        run(1'b1, 1, 32'h3);
        wr(`QER_OFF_CTRL, ctrl(cond_motion, multiply_then_divide, phase_first_leads, 1'b0,
                               route_line2, both_transitions));
        run(1'b1, 3, 32'h4);
        rd(`QER_OFF_TRIG, 32'h2b);
        $display("t_scale finished");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_lines;
        t_direction;
        t_edges;
        t_route;
        t_scale;
        summarize;
    end

    // the full sequence needs about 1000 cycles
    initial begin
        #150000;
        mismatches++;
        summarize;
    end
endmodule
`default_nettype wire
